//--- gear_defines.vh
// How it works
// - Command times num/den, feedback times den/num
// - Per-rev mode: encoder resolution over pulses-per-rev
// - Select pins pick one of four numerators
// - Numerator switches immediately with select pins
// - In-position asserts when droop within range
// - In-position off in velocity/torque modes
// - Range unit: command pulses or encoder pulses
// - On-condition 0/1/2 adds completion and start-off
// - Default range 25600 network, 400 pulse-train
// - In-position re-evaluated every cycle
// - Bad gear ratio raises parameter error alarm
// - Numerator and denominator reset to 1
`ifndef GEAR_DEFINES_VH
`define GEAR_DEFINES_VH

// ----------------------------------------------------------------
// Register map (word index on the plain port)
// ----------------------------------------------------------------
`define REG_BASE_NUM 4'h0
`define REG_NUM_TWO 4'h1
`define REG_NUM_THREE 4'h2
`define REG_NUM_FOUR 4'h3
`define REG_DENOM 4'h4
`define REG_PPR 4'h5
`define REG_RANGE 4'h6
`define REG_CONFIG 4'h7
`define REG_STATUS 4'h8
`define REG_DROOP 4'h9

// ----------------------------------------------------------------
// Config fields and modes
// ----------------------------------------------------------------
`define CFG_UNIT_BIT 0
`define CFG_ONCOND_LSB 1
`define CFG_GEARSRC_BIT 3
`define CFG_MODE_LSB 4
`define MODE_POSITION 2'h0

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define RST_NUM 32'h0000_0001
`define RST_DENOM 32'h0000_0001
`define RST_PPR 32'h0000_2710
`define RST_RANGE_NET 32'h0000_6400
`define RST_RANGE_PULSE 32'h0000_0190
`define NUM_MAX 32'h7FFF_FFFF
`define ENC_RES 32'h0400_0000

`endif

//--- gear_scale.v
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Exact ratio scaler with remainder carry: out = in*mul/div
// ----------------------------------------------------------------
module gear_scale (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_en,
   input wire signed [31:0] i_delta,
   input wire [31:0] i_mul,
   input wire [31:0] i_div,
   output reg signed [31:0] o_delta
);
   reg signed [95:0] rem_q;
   reg signed [95:0] acc;
   reg signed [95:0] quo;
   reg signed [95:0] divs;

   // Remainder kept so rounding never accumulates over endless motion
   always @* begin
      divs = $signed({64'h0000_0000_0000_0000, i_div});
      acc = rem_q + i_delta * $signed({32'h0000_0000, i_mul});
      if (i_div == 32'h0000_0000) begin
         quo = 96'sh0;
      end else begin
         quo = acc / divs;
      end
   end

   // Output step and carried remainder
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rem_q <= 96'sh0;
         o_delta <= 32'sh0;
      end else if (i_en) begin
         o_delta <= quo[31:0];
         rem_q <= acc - quo * divs;
      end else begin
         o_delta <= 32'sh0;
      end
   end
endmodule

//--- gear_ratio_and_in_position.v
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "gear_defines.vh"
module gear_ratio_and_in_position #(
   parameter PULSE_TRAIN_VARIANT = 0,
   parameter [31:0] ENCODER_RES = `ENC_RES
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire [3:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire i_cycle_tick,
   input wire signed [31:0] i_cmd_delta,
   input wire signed [31:0] i_fb_delta,
   input wire i_numerator_select_low,
   input wire i_numerator_select_high,
   input wire i_cmd_done,
   input wire i_start,
   output reg [31:0] o_rdata,
   output reg signed [31:0] o_cmd_scaled,
   output reg signed [31:0] o_fb_scaled,
   output reg o_in_position_output,
   output reg o_parameter_error_alarm
);
   localparam [31:0] RANGE_RST = PULSE_TRAIN_VARIANT ? `RST_RANGE_PULSE : `RST_RANGE_NET;

   reg [31:0] num_q [0:3];
   reg [31:0] denom_q;
   reg [31:0] ppr_q;
   reg [31:0] range_q;
   reg [7:0] cfg_q;
   reg signed [47:0] droop_q;
   reg tick_q;
   reg signed [31:0] fb_hold_q;

   wire [1:0] sel;
   wire [31:0] gear_numerator;
   wire [31:0] gear_denominator;
   wire signed [31:0] cmd_step;
   wire signed [31:0] fb_step;
   wire ratio_bad;
   wire [47:0] droop_mag;
   wire [47:0] range_enc;
   wire [79:0] range_prod;
   wire [79:0] range_quo;
   wire in_range;
   reg cond_ok;
   reg position_mode;

   // ----------------------------------------------------------------
   // Gear ratio selection
   // ----------------------------------------------------------------
   // Select pins read combinationally so a change takes the next step
   assign sel = {i_numerator_select_high, i_numerator_select_low};
   assign gear_numerator = cfg_q[`CFG_GEARSRC_BIT] ? ENCODER_RES : num_q[sel];
   assign gear_denominator = cfg_q[`CFG_GEARSRC_BIT] ? ppr_q : denom_q;

   // Zero terms or numerator beyond the signed 32-bit limit are refused
   assign ratio_bad = (gear_numerator == 32'h0000_0000) || (gear_denominator == 32'h0000_0000) ||
                      (gear_numerator > `NUM_MAX);

   // ----------------------------------------------------------------
   // Scalers: forward on command, inverse on feedback
   // ----------------------------------------------------------------
   gear_scale u_cmd_scale (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_en(i_cycle_tick & ~ratio_bad),
      .i_delta(i_cmd_delta),
      .i_mul(gear_numerator),
      .i_div(gear_denominator),
      .o_delta(cmd_step)
   );

   gear_scale u_fb_scale (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_en(i_cycle_tick & ~ratio_bad),
      .i_delta(i_fb_delta),
      .i_mul(gear_denominator),
      .i_div(gear_numerator),
      .o_delta(fb_step)
   );

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Numerator bank; all four reset to one
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_num
         always @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
               num_q[g] <= `RST_NUM;
            end else if (i_wr && (i_addr == `REG_BASE_NUM + g)) begin
               num_q[g] <= i_wdata;
            end
         end
      end
   endgenerate

   // Remaining configuration registers
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         denom_q <= `RST_DENOM;
         ppr_q <= `RST_PPR;
         range_q <= RANGE_RST;
         cfg_q <= 8'h00;
      end else if (i_wr) begin
         case (i_addr)
            `REG_DENOM: denom_q <= i_wdata;
            `REG_PPR: ppr_q <= i_wdata;
            `REG_RANGE: range_q <= i_wdata;
            `REG_CONFIG: cfg_q <= i_wdata[7:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Droop and in-position
   // ----------------------------------------------------------------
   // Feedback step caught on the tick; the link may change it right after
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         fb_hold_q <= 32'sh0;
      end else if (i_cycle_tick) begin
         fb_hold_q <= i_fb_delta;
      end
   end

   // Droop tracked in encoder pulses: scaled command less feedback
   // Both terms belong to the same tick, one edge after it was taken
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         droop_q <= 48'sh0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= i_cycle_tick;
         if (tick_q) begin
            droop_q <= droop_q + cmd_step - fb_hold_q;
         end
      end
   end

   assign droop_mag = droop_q[47] ? 48'h0 - droop_q : droop_q;

   // Command-unit range converted to encoder pulses with the active ratio
   assign range_prod = range_q * gear_numerator;
   // Zero divisor guarded; the alarm already flags that ratio as unusable
   assign range_quo = (gear_denominator == 32'h0000_0000) ? 80'h0 : range_prod / gear_denominator;
   // Upper bits dropped on purpose: droop itself is only 48 bits wide
   assign range_enc = range_quo[47:0];

   // Unit select picks encoder or command interpretation
   assign in_range = cfg_q[`CFG_UNIT_BIT] ? (droop_mag <= {16'h0000, range_q})
                                          : (droop_mag <= range_enc);

   // On-condition: 0 range, 1 plus done, 2 plus start off
   // Code 3 treated like 2, the strictest choice, rather than left open
   always @* begin
      cond_ok = 1'b0;
      case (cfg_q[`CFG_ONCOND_LSB +: 2])
         2'h0: begin
            cond_ok = 1'b1;
         end
         2'h1: begin
            cond_ok = i_cmd_done;
         end
         2'h2: begin
            cond_ok = i_cmd_done & ~i_start;
         end
         default: begin
            cond_ok = i_cmd_done & ~i_start;
         end
      endcase
   end

   // Only position mode may report in-position; others hold it off
   always @* begin
      position_mode = 1'b0;
      case (cfg_q[`CFG_MODE_LSB +: 2])
         `MODE_POSITION: begin
            position_mode = 1'b1;
         end
         default: begin
            position_mode = 1'b0;
         end
      endcase
   end

   // Evaluated every clock so overshoot drops the output again
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_in_position_output <= 1'b0;
         o_parameter_error_alarm <= 1'b0;
         o_cmd_scaled <= 32'sh0;
         o_fb_scaled <= 32'sh0;
      end else begin
         o_in_position_output <= position_mode & in_range & cond_ok;
         o_parameter_error_alarm <= ratio_bad;
         o_cmd_scaled <= cmd_step;
         o_fb_scaled <= fb_step;
      end
   end

   // ----------------------------------------------------------------
   // Read port, data one cycle after strobe
   // ----------------------------------------------------------------
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         case (i_addr)
            `REG_BASE_NUM: o_rdata <= num_q[0];
            `REG_NUM_TWO: o_rdata <= num_q[1];
            `REG_NUM_THREE: o_rdata <= num_q[2];
            `REG_NUM_FOUR: o_rdata <= num_q[3];
            `REG_DENOM: o_rdata <= denom_q;
            `REG_PPR: o_rdata <= ppr_q;
            `REG_RANGE: o_rdata <= range_q;
            `REG_CONFIG: o_rdata <= {24'h00_0000, cfg_q};
            `REG_STATUS: o_rdata <= {28'h000_0000, sel, o_parameter_error_alarm, o_in_position_output};
            `REG_DROOP: o_rdata <= droop_q[31:0];
            default: o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
endmodule

//--- gear_ratio_assertions.sv
`timescale 1ns/10ps
// --------------------------------------------
// Port checks for the gear and in-position block
// --------------------------------------------
module gear_ratio_chk (
   input wire i_ref_clk,
   input wire i_rst,
   input wire [3:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire i_cycle_tick,
   input wire [31:0] o_rdata,
   input wire signed [31:0] o_cmd_scaled,
   input wire signed [31:0] o_fb_scaled,
   input wire o_in_position_output,
   input wire o_parameter_error_alarm
);
   // One clock domain, so one clocking and one disable for all
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // Mirror of the gear source bit, so the zero-denominator check knows which term is live
   reg gear_src_q;
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         gear_src_q <= 1'b0;
      end else if (i_wr && i_addr == 4'h7) begin
         gear_src_q <= i_wdata[3];
      end
   end
   property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_unmapped; $past(i_rd) && $past(i_addr) > 4'h9 |-> o_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_wr_rd;
      $past(i_wr, 3) && !$past(i_wr, 2) && !$past(i_wr) && $past(i_rd) && $past(i_addr, 3) == $past(i_addr)
         && $past(i_addr) < 4'h5 |-> o_rdata == $past(i_wdata, 3);
   endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("ratio register readback wrong");
   property p_scaled_idle; !$past(i_cycle_tick, 2) |-> o_cmd_scaled == 0 && o_fb_scaled == 0; endproperty
   a_scaled_idle: assert property (p_scaled_idle) else $error("scaled output without tick");
   // Alarm held three samples covers every pipeline stage
   property p_alarm_gate; o_parameter_error_alarm [*3] |-> o_cmd_scaled == 0; endproperty
   a_alarm_gate: assert property (p_alarm_gate) else $error("scaler ran during alarm");
   property p_status;
      $past(i_rd) && $past(i_addr) == 4'h8
         |-> o_rdata[1:0] == {$past(o_parameter_error_alarm), $past(o_in_position_output)};
   endproperty
   a_status: assert property (p_status) else $error("status flags disagree with pins");
   property p_den_zero;
      i_wr && i_addr == 4'h4 && i_wdata == 32'h0 && !gear_src_q |-> ##[1:2] o_parameter_error_alarm;
   endproperty
   a_den_zero: assert property (p_den_zero) else $error("zero denominator without alarm");
   property p_rst_out; $fell(i_rst) |-> !o_in_position_output && o_cmd_scaled == 0; endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
   c_inp: cover property ($rose(o_in_position_output));
   c_alarm: cover property ($rose(o_parameter_error_alarm));
   c_scaled: cover property (o_cmd_scaled != 0);
endmodule

bind gear_ratio_and_in_position gear_ratio_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cycle_tick(i_cycle_tick), .o_rdata(o_rdata),
   .o_cmd_scaled(o_cmd_scaled), .o_fb_scaled(o_fb_scaled), .o_in_position_output(o_in_position_output),
   .o_parameter_error_alarm(o_parameter_error_alarm));

//--- motion_ctrl_model.sv
`timescale 1ns/10ps
// --------------------------------------------
// Motion controller stand-in
// --------------------------------------------
module motion_ctrl_model (
   input wire i_ref_clk,
   input wire i_go,
   input wire signed [31:0] i_cmd,
   input wire signed [31:0] i_fb,
   output reg o_tick,
   output reg signed [31:0] o_cmd_delta,
   output reg signed [31:0] o_fb_delta
);
   // One-cycle tick; deltas flip outside it so stale data never looks valid
   initial begin
      o_tick = 1'b0;
      o_cmd_delta = 32'h0;
      o_fb_delta = 32'h0;
   end
   always @(posedge i_ref_clk) begin
      o_tick <= i_go;
      o_cmd_delta <= i_go ? i_cmd : ~o_cmd_delta;
      o_fb_delta <= i_go ? i_fb : ~o_fb_delta;
   end
endmodule

//--- gear_ratio_and_in_position_tb.sv
`timescale 1ns/10ps
module gear_ratio_and_in_position_tb;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0;
   logic sel_lo = 1'b0, sel_hi = 1'b0, done = 1'b0, start = 1'b0, tick, inp, alarm;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0, rdata;
   logic signed [31:0] cmd = 32'h0, fb = 32'h0, cmd_d, fb_d, cmd_s, fb_s;
   logic [31:0] nums [4] = '{32'h3, 32'h2, 32'h4, 32'h5};
   int bad_count = 0, samples_checked = 0, n;
   // --------------------------------------------
   // Clock, partner and device
   // --------------------------------------------
   always #50 i_ref_clk = ~i_ref_clk;
   motion_ctrl_model ctrl (.i_ref_clk(i_ref_clk), .i_go(go), .i_cmd(cmd), .i_fb(fb), .o_tick(tick),
      .o_cmd_delta(cmd_d), .o_fb_delta(fb_d));
   // Small encoder resolution keeps the per-rev ratio easy to predict
   gear_ratio_and_in_position #(.PULSE_TRAIN_VARIANT(0), .ENCODER_RES(32'h8)) DUT (.i_ref_clk(i_ref_clk),
      .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cycle_tick(tick),
      .i_cmd_delta(cmd_d), .i_fb_delta(fb_d), .i_numerator_select_low(sel_lo), .i_numerator_select_high(sel_hi),
      .i_cmd_done(done), .i_start(start), .o_rdata(rdata), .o_cmd_scaled(cmd_s), .o_fb_scaled(fb_s),
      .o_in_position_output(inp), .o_parameter_error_alarm(alarm));
   // --------------------------------------------
   // Tasks
   // --------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      if (bad_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 chk("rdata", rdata, e);
      @(posedge i_ref_clk);
   endtask
   // One control cycle; scaled outputs stand for one cycle, two edges after the tick
   task automatic step(input logic signed [31:0] c, f, ec, ef);
      cmd <= c;
      fb <= f;
      go <= 1'b1;
      @(posedge i_ref_clk);
      go <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1 chk("cmd_scaled", cmd_s, ec);
      chk("fb_scaled", fb_s, ef);
      repeat (3) @(posedge i_ref_clk);
   endtask
   // Flags {alarm, in-position} after they have had time to follow
   task automatic st(input logic [1:0] e);
      repeat (3) @(posedge i_ref_clk);
      #1 chk("flags", {30'h0, alarm, inp}, {30'h0, e});
      @(posedge i_ref_clk);
   endtask
   // --------------------------------------------
   // Sequence
   // --------------------------------------------
   initial begin
      repeat (4) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      rd(4'h0, 32'h1);
      rd(4'h4, 32'h1);
      rd(4'h6, 32'h0000_6400);
      rd(4'h5, 32'h2710);
      rd(4'hF, 32'h0);
      st(2'b01);
      wr(4'h0, 32'h3);
      rd(4'h0, 32'h3);
      step(10, 30, 30, 10);
      wr(4'h1, 32'h2);
      wr(4'h2, 32'h4);
      wr(4'h3, 32'h5);
      // Selects move only between steps, so no shock calls for smoothing
      for (n = 0; n < 4; n++) begin
         sel_hi <= n[1];
         sel_lo <= n[0];
         step(6, 32'h6 * nums[n], 32'h6 * nums[n], 6);
         rd(4'h8, {28'h0, n[1:0], 2'b01});
      end
      sel_hi <= 1'b0;
      sel_lo <= 1'b0;
      wr(4'h0, 32'h1);
      wr(4'h6, 32'h5);
      wr(4'h7, 32'h1);
      step(6, 0, 6, 0);
      st(2'b00);
      step(0, 1, 0, 1);
      st(2'b01);
      wr(4'h6, 32'h3);
      st(2'b00);
      wr(4'h0, 32'h2);
      wr(4'h7, 32'h0);
      st(2'b01);
      wr(4'h7, 32'h2);
      st(2'b00);
      done <= 1'b1;
      st(2'b01);
      start <= 1'b1;
      wr(4'h7, 32'h4);
      st(2'b00);
      start <= 1'b0;
      st(2'b01);
      for (n = 1; n < 4; n++) begin
         wr(4'h7, n << 4);
         st(2'b00);
      end
      wr(4'h7, 32'h1);
      wr(4'h4, 32'h0);
      st(2'b10);
      wr(4'h4, 32'h1);
      wr(4'h0, 32'h8000_0000);
      st(2'b10);
      wr(4'h0, 32'h7FFF_FFFF);
      st(2'b00);
      wr(4'h0, 32'h8000_0000);
      step(10, 0, 0, 0);
      wr(4'h0, 32'h1);
      wr(4'h5, 32'h4);
      wr(4'h7, 32'h8);
      step(5, 4, 10, 2);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      rd(4'h0, 32'h1);
      end_sim();
   end
   // Watchdog so a stalled sequence still reaches the verdict
   initial begin
      repeat (5000) @(posedge i_ref_clk);
      bad_count++;
      end_sim();
   end
endmodule
